// ===== hw/cam_pkg.sv
// constants, types and register map of the embedded search memory
// What this block does
// - holds 32 entries of 32 bits each
// - key compared against all entries at once
// - match flag high when any entry equals key
// - don't-care bits never affect an entry's match
// - encoded mode reports binary index of match
// - unencoded mode: 16 lines over two cycles
// - unencoded mode shows every duplicate matching entry
// - write takes two cycles, three with don't-cares
// - entries preloaded at reset, writable at run time
// - single-port memory mode shares one port
// - pipeline registers asynchronously clearable; array and bus registers reset synchronously
// - input and output register stages kept separate
// - optional registers selectable on six paths
// - clock, clear and strobes driven by user logic
// - lookup mode returns fixed contents, no writes
package cam_pkg;
  localparam int unsigned DEPTH   = 32;  // entries in the array
  localparam int unsigned WIDTH   = 32;  // bits per entry
  localparam int unsigned IDX_W   = 5;   // entry index width
  localparam int unsigned LINES_W = 16;  // result lines
  localparam int unsigned AXI_AW  = 8;   // register bus address width

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_HITS   = 8'h10;

  // control register fields
  localparam int unsigned CTRL_UNENC   = 0;  // 1: unencoded result lines
  localparam int unsigned CTRL_MODE_LO = 1;  // two bits of memory mode
  localparam int unsigned CTRL_REG_LO  = 3;  // six path register selects
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] CTRL_USED    = 32'h0000_01ff;

  // register select bit order inside the six-bit field
  localparam int unsigned SEL_DIN   = 0;
  localparam int unsigned SEL_DOUT  = 1;
  localparam int unsigned SEL_RADDR = 2;
  localparam int unsigned SEL_WADDR = 3;
  localparam int unsigned SEL_WSTB  = 4;
  localparam int unsigned SEL_RSTB  = 5;

  // status event bits, also the mask layout
  localparam int unsigned EV_HIT    = 0;
  localparam int unsigned EV_MISS   = 1;
  localparam int unsigned EV_WDONE  = 2;
  localparam int unsigned EV_WABORT = 3;
  localparam int unsigned EV_WREJ   = 4;
  localparam int unsigned EV_N      = 5;
  localparam logic [EV_N-1:0] STATUS_RESET = 5'h00;
  localparam logic [EV_N-1:0] MASK_RESET   = 5'h00;

  // result register fields
  localparam int unsigned RES_MATCH = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {MODE_SEARCH, MODE_RAM, MODE_ROM, MODE_SPARE} memMode_t;
  typedef enum logic [1:0] {WR_IDLE, WR_SECOND, WR_THIRD} wrState_t;

  typedef struct packed {
    logic [IDX_W-1:0] addr;      // entry to write
    logic [WIDTH-1:0] data;      // word to store
    logic [WIDTH-1:0] dontCare;  // 1 = bit excluded from compare
  } wrCmd_t;

  typedef struct packed {
    logic               valid;  // result lines meaningful this cycle
    logic               match;  // at least one entry matched
    logic               phase;  // 0: entries 0-15, 1: entries 16-31
    logic [LINES_W-1:0] lines;  // index or one half of the hit vector
  } camResult_t;

  // content loaded at reset; entry i holds i, nothing masked
  function automatic logic [WIDTH-1:0] preloadWord(input int unsigned i);
    preloadWord = WIDTH'(i);
  endfunction : preloadWord
endpackage : cam_pkg

// ===== hw/embedded_cam_block.sv
// search memory core with user-side ports and register bus for control
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module embedded_cam_block
  import cam_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              arrayClearn,
  // user-side search, write and fetch
  input  wire logic              searchStrobe,
  input  wire logic [WIDTH-1:0]  searchKey,
  output logic                   searchReady,
  input  wire logic              writeStrobe,
  input  wire wrCmd_t            writeCmd,
  output logic                   writeDone,
  input  wire logic              fetchStrobe,
  input  wire logic [IDX_W-1:0]  fetchAddr,
  output logic                   fetchReady,
  output logic                   fetchValid,
  output logic [WIDTH-1:0]       fetchData,
  output camResult_t             result,
  output logic                   irq,
  // register bus
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [AXI_AW-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp
);

  logic [31:0]       ctrl;          // mode and register selects
  logic [EV_N-1:0]   status;        // sticky events
  logic [EV_N-1:0]   irqMask;       // 1 = event reaches irq
  logic [EV_N-1:0]   events;        // one-cycle event pulses
  logic [WIDTH-1:0]  entry [DEPTH]; // stored words
  logic [WIDTH-1:0]  dcare [DEPTH]; // don't-care masks per entry
  logic [DEPTH-1:0]  hits;          // live compare vector
  logic [DEPTH-1:0]  hitVec;        // captured compare vector
  logic [IDX_W-1:0]  hitIdx;        // lowest matching index
  logic [IDX_W-1:0]  lastIdx;       // index of last search
  logic              lastMatch;     // match of last search
  logic              phaseTwo;      // second unencoded cycle pending
  wrState_t          wrState;       // write sequencer
  wrCmd_t            wrHold;        // command captured at first cycle
  camResult_t        resA;          // first output stage
  camResult_t        resB;          // optional second output stage
  logic              fetchA;        // fetch valid, first stage
  logic              fetchB;        // fetch valid, second stage
  logic [WIDTH-1:0]  fetchDataA;    // fetch data, first stage
  logic [WIDTH-1:0]  fetchDataB;    // fetch data, second stage
  // input-side staging registers
  logic              regSearch;
  logic [WIDTH-1:0]  regKey;
  logic              regWrite;
  wrCmd_t            regCmd;
  logic              regFetch;
  logic [IDX_W-1:0]  regFetchAddr;
  // selected input paths
  logic              selSearch;
  logic [WIDTH-1:0]  selKey;
  logic              selWrite;
  wrCmd_t            selCmd;
  logic              selFetch;
  logic [IDX_W-1:0]  selFetchAddr;
  memMode_t          mode;
  logic [5:0]        regSel;
  logic              unenc;
  logic              searchGo;
  logic              fetchGo;
  logic              commit;

  assign mode   = memMode_t'(ctrl[CTRL_MODE_LO +: 2]);
  assign regSel = ctrl[CTRL_REG_LO +: 6];
  assign unenc  = ctrl[CTRL_UNENC];

  // each path independently takes the raw pin or its staged copy
  always_comb
  begin
    selKey               = regSel[SEL_DIN]   ? regKey             : searchKey;
    selCmd.data          = regSel[SEL_DIN]   ? regCmd.data        : writeCmd.data;
    selCmd.dontCare      = regSel[SEL_DIN]   ? regCmd.dontCare    : writeCmd.dontCare;
    selCmd.addr          = regSel[SEL_WADDR] ? regCmd.addr        : writeCmd.addr;
    selWrite             = regSel[SEL_WSTB]  ? regWrite           : writeStrobe;
    selFetch             = regSel[SEL_RSTB]  ? regFetch           : fetchStrobe;
    selFetchAddr         = regSel[SEL_RADDR] ? regFetchAddr       : fetchAddr;
    // search strobe follows the read strobe select, it is a read of the array
    selSearch            = regSel[SEL_RSTB]  ? regSearch          : searchStrobe;
  end

  // input staging; cleared without the clock by the array clear
  always_ff @(posedge core_clk or negedge arrayClearn)
  begin
    if (!arrayClearn)
      {regSearch, regKey, regWrite, regCmd, regFetch, regFetchAddr} <= '0;
    else if (!resetn)
      {regSearch, regKey, regWrite, regCmd, regFetch, regFetchAddr} <= '0;
    else
      {regSearch, regKey, regWrite, regCmd, regFetch, regFetchAddr} <=
        {searchStrobe, searchKey, writeStrobe, writeCmd, fetchStrobe, fetchAddr};
  end

  // one comparator per entry, all in parallel
  generate
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_cmp
      // masked bits forced equal so they cannot spoil a match
      assign hits[i] = &(~(entry[i] ^ selKey) | dcare[i]);
    end
  endgenerate

  // lowest matching index; with duplicates the lowest one wins
  always_comb
  begin
    hitIdx = '0;
    for (int i = DEPTH - 1; i >= 0; i--)
      if (hits[i])
        hitIdx = IDX_W'(i);
  end

  // a search cannot start while the second unencoded half is due
  assign searchReady = (mode == MODE_SEARCH) && !phaseTwo;
  assign searchGo    = selSearch && searchReady;
  // single port: a write sequence owns the port until it ends
  assign fetchReady  = (mode == MODE_RAM || mode == MODE_ROM) && (wrState == WR_IDLE);
  assign fetchGo     = selFetch && fetchReady && !selWrite;

  // write sequencer: strobe must stay high two or three cycles
  always_ff @(posedge core_clk or negedge arrayClearn)
  begin
    if (!arrayClearn)
    begin
      wrState <= WR_IDLE;
      wrHold  <= '0;
    end
    else if (!resetn)
    begin
      wrState <= WR_IDLE;
      wrHold  <= '0;
    end
    else
    begin
      case (wrState)
        // lookup mode refuses run-time writes outright
        WR_IDLE:
          if (selWrite && mode != MODE_ROM)
          begin
            wrHold  <= selCmd;
            wrState <= WR_SECOND;
          end
        // masked words need one more cycle to store the mask
        WR_SECOND:
          if (selWrite && (|wrHold.dontCare))
            wrState <= WR_THIRD;
          else
            wrState <= WR_IDLE;
        WR_THIRD:
          wrState <= WR_IDLE;
        default:
          wrState <= WR_IDLE;
      endcase
    end
  end

  // commit at the last held cycle of the sequence
  assign commit = selWrite &&
                  ((wrState == WR_SECOND && !(|wrHold.dontCare)) ||
                   (wrState == WR_THIRD));

  // array storage: preload at reset, then run-time writes
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        entry[i] <= preloadWord(i);
        dcare[i] <= '0;
      end
    end
    else if (commit)
    begin
      entry[wrHold.addr] <= wrHold.data;
      dcare[wrHold.addr] <= wrHold.dontCare;
    end
  end

  // search capture and result sequencing
  always_ff @(posedge core_clk or negedge arrayClearn)
  begin
    if (!arrayClearn)
      {hitVec, lastIdx, lastMatch, phaseTwo, resA} <= '0;
    else if (!resetn)
      {hitVec, lastIdx, lastMatch, phaseTwo, resA} <= '0;
    else if (searchGo)
    begin
      hitVec    <= hits;
      lastIdx   <= hitIdx;
      lastMatch <= |hits;
      phaseTwo  <= unenc;
      // unencoded shows the lower half now, encoded the lowest index
      resA      <= '{valid: 1'b1, match: |hits, phase: 1'b0,
                     lines: unenc ? hits[LINES_W-1:0] : LINES_W'(hitIdx)};
    end
    else if (phaseTwo)
    begin
      phaseTwo <= 1'b0;
      resA     <= '{valid: 1'b1, match: resA.match, phase: 1'b1,
                    lines: hitVec[DEPTH-1:LINES_W]};
    end
    else
      resA.valid <= 1'b0;
  end

  // fetch path for plain memory and lookup modes
  always_ff @(posedge core_clk or negedge arrayClearn)
  begin
    if (!arrayClearn)
      {fetchA, fetchDataA} <= '0;
    else if (!resetn)
      {fetchA, fetchDataA} <= '0;
    else
    begin
      fetchA <= fetchGo;
      if (fetchGo)
        fetchDataA <= entry[selFetchAddr];
    end
  end

  // output stage kept apart from input staging so it can be retimed alone
  always_ff @(posedge core_clk or negedge arrayClearn)
  begin
    if (!arrayClearn)
      {resB, fetchB, fetchDataB} <= '0;
    else if (!resetn)
      {resB, fetchB, fetchDataB} <= '0;
    else
      {resB, fetchB, fetchDataB} <= {resA, fetchA, fetchDataA};
  end

  assign result     = regSel[SEL_DOUT] ? resB : resA;
  assign fetchValid = regSel[SEL_DOUT] ? fetchB : fetchA;
  assign fetchData  = regSel[SEL_DOUT] ? fetchDataB : fetchDataA;
  assign writeDone  = commit;

  // event pulses feeding the sticky status
  always_comb
  begin
    events[EV_HIT]    = searchGo && (|hits);
    events[EV_MISS]   = searchGo && !(|hits);
    events[EV_WDONE]  = commit;
    events[EV_WABORT] = (wrState != WR_IDLE) && !selWrite;
    events[EV_WREJ]   = selWrite && (wrState == WR_IDLE) && (mode == MODE_ROM);
  end

  // register bus slave
  logic              awHeld;
  logic              wHeld;
  logic [AXI_AW-1:0] awAddrQ;
  logic [31:0]       wDataQ;
  logic [3:0]        wStrbQ;
  logic              doWrite;
  logic [31:0]       byteMask;
  logic [31:0]       rdWord;
  logic              rdOk;

  assign awready = !awHeld && !bvalid;
  assign wready  = !wHeld && !bvalid;
  assign arready = !rvalid;
  assign doWrite = awHeld && wHeld && !bvalid;

  // expand byte strobes into a bit mask
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      byteMask[b*8 +: 8] = {8{wStrbQ[b]}};
  end

  // address and data taken in either order, answered after both
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      {awHeld, wHeld, awAddrQ, wDataQ, wStrbQ, bvalid, bresp} <= '0;
    else
    begin
      if (awvalid && awready)
        {awHeld, awAddrQ} <= {1'b1, awaddr};
      if (wvalid && wready)
        {wHeld, wDataQ, wStrbQ} <= {1'b1, wdata, wstrb};
      if (doWrite)
      begin
        {awHeld, wHeld, bvalid} <= 3'b001;
        // unmapped offsets answer with an error, no effect
        bresp <= (awAddrQ == OFS_CTRL || awAddrQ == OFS_STATUS || awAddrQ == OFS_MASK ||
                  awAddrQ == OFS_RESULT || awAddrQ == OFS_HITS) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // control and mask registers
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ctrl    <= CTRL_RESET;
      irqMask <= MASK_RESET;
    end
    else if (doWrite && awAddrQ == OFS_CTRL)
      ctrl <= ((ctrl & ~byteMask) | (wDataQ & byteMask)) & CTRL_USED;
    else if (doWrite && awAddrQ == OFS_MASK)
      irqMask <= (irqMask & ~byteMask[EV_N-1:0]) | (wDataQ[EV_N-1:0] & byteMask[EV_N-1:0]);
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      status <= STATUS_RESET;
    else if (doWrite && awAddrQ == OFS_STATUS)
      status <= (status & ~(wDataQ[EV_N-1:0] & byteMask[EV_N-1:0])) | events;
    else
      status <= status | events;
  end

  assign irq = |(status & irqMask);

  // read decode
  always_comb
  begin
    rdWord = '0;
    rdOk   = 1'b1;
    case (araddr)
      OFS_CTRL:   rdWord = ctrl;
      OFS_STATUS: rdWord[EV_N-1:0] = status;
      OFS_MASK:   rdWord[EV_N-1:0] = irqMask;
      OFS_RESULT:
      begin
        rdWord[IDX_W-1:0] = lastIdx;
        rdWord[RES_MATCH] = lastMatch;
      end
      OFS_HITS:   rdWord = hitVec;
      default:    rdOk = 1'b0;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      {rvalid, rdata, rresp} <= '0;
    else if (arvalid && arready)
      {rvalid, rdata, rresp} <= {1'b1, rdWord, rdOk ? RESP_OKAY : RESP_SLVERR};
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

endmodule : embedded_cam_block
`default_nettype wire

// ===== bench/cam_user.sv
// user-side model issuing searches, writes and fetches
`timescale 1ns/10ps
`default_nettype none
module cam_user
  import cam_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             searchReady,
  input  wire logic             writeDone,
  input  wire logic             fetchReady,
  input  wire logic             fetchValid,
  input  wire logic [WIDTH-1:0] fetchData,
  input  wire camResult_t       result,
  output logic                  searchStrobe,
  output logic [WIDTH-1:0]      searchKey,
  output logic                  writeStrobe,
  output wrCmd_t                writeCmd,
  output logic                  fetchStrobe,
  output logic [IDX_W-1:0]      fetchAddr
);
  // quiet request lines at time zero
  initial
  begin
    searchStrobe = 1'b0;
    searchKey    = '0;
    writeStrobe  = 1'b0;
    writeCmd     = '0;
    fetchStrobe  = 1'b0;
    fetchAddr    = '0;
  end

  // one search; r0 first result cycle, the cycle after
  task automatic search(input logic [WIDTH-1:0] k, output camResult_t r0, output camResult_t r1);
    @(posedge core_clk);
    searchStrobe <= 1'b1;
    searchKey    <= k;
    do @(posedge core_clk); while (searchReady !== 1'b1);
    searchStrobe <= 1'b0;
    searchKey    <= ~k;  // released key flipped so stale bits never pass
    do @(posedge core_clk); while (result.valid !== 1'b1);
    r0 = result;
    @(posedge core_clk);
    r1 = result;
  endtask : search

  // strobe held until commit or until hold cycles ran out (abort)
  task automatic write(input wrCmd_t c, input int hold, output int n, output logic dn);
    @(posedge core_clk);
    writeStrobe <= 1'b1;
    writeCmd    <= c;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (writeDone !== 1'b1 && n < hold);
    dn = (writeDone === 1'b1);
    writeStrobe <= 1'b0;
    writeCmd    <= wrCmd_t'(~c);
  endtask : write

  // single word read in ram or lookup mode
  task automatic fetch(input logic [IDX_W-1:0] a, output logic [WIDTH-1:0] v);
    @(posedge core_clk);
    fetchStrobe <= 1'b1;
    fetchAddr   <= a;
    do @(posedge core_clk); while (fetchReady !== 1'b1);
    fetchStrobe <= 1'b0;
    fetchAddr   <= ~a;
    do @(posedge core_clk); while (fetchValid !== 1'b1);
    v = fetchData;
  endtask : fetch
endmodule : cam_user
`default_nettype wire

// ===== bench/embedded_cam_block_assertions.sv
// port-level checker for the search memory, bound to the top
`timescale 1ns/10ps
`default_nettype none
module embedded_cam_block_checker
  import cam_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       arrayClearn,
  input wire logic       searchStrobe,
  input wire logic       searchReady,
  input wire logic       writeStrobe,
  input wire logic       writeDone,
  input wire logic       fetchStrobe,
  input wire logic       fetchReady,
  input wire logic       fetchValid,
  input wire camResult_t result,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready
);
  default clocking cb @(posedge core_clk);
  endclocking
  // either clear wipes pipeline state, so both quiet the checks
  default disable iff (!resetn || !arrayClearn);

  sequence s_search;
    searchStrobe && searchReady;
  endsequence
  sequence s_wboth;
    awvalid && awready && wvalid && wready;
  endsequence

  // staged strobe and output stage each add one cycle
  property p_search_lat;
    s_search |-> ##[1:3] result.valid;
  endproperty
  a_search_lat: assert property (p_search_lat) else $error("search gave no result");
  property p_nomatch;
    result.valid && !result.match |-> result.lines == '0;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("lines set without match");
  property p_unenc_pair;
    result.valid && result.phase |-> $past(result.valid) && !$past(result.phase)
      && $stable(result.match);
  endproperty
  a_unenc_pair: assert property (p_unenc_pair) else $error("upper half out of turn");
  property p_wdone_held;
    writeDone |-> writeStrobe && $past(writeStrobe);
  endproperty
  a_wdone_held: assert property (p_wdone_held) else $error("commit without held strobe");
  property p_wdone_gap;
    writeDone |=> !writeDone;
  endproperty
  a_wdone_gap: assert property (p_wdone_gap) else $error("write done twice in a row");
  property p_b_after;
    s_wboth |-> ##[1:2] bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("no write response");
  property p_r_after;
    arvalid && arready |-> ##[1:2] rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("no read response");
  property p_r_drop;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read response not released");
  property p_fetch_lat;
    fetchStrobe && fetchReady && !writeStrobe |-> ##[1:2] fetchValid;
  endproperty
  a_fetch_lat: assert property (p_fetch_lat) else $error("fetch gave no word");
endmodule : embedded_cam_block_checker

bind embedded_cam_block embedded_cam_block_checker u_chk (.core_clk, .resetn, .arrayClearn,
  .searchStrobe, .searchReady, .writeStrobe, .writeDone, .fetchStrobe, .fetchReady,
  .fetchValid, .result, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .rvalid, .rready);
`default_nettype wire

// ===== bench/embedded_cam_block_tb.sv
// self-checking bench for the embedded search memory
`timescale 1ns/10ps
`default_nettype none
module embedded_cam_block_tb
  import cam_pkg::*;
;
  typedef struct packed {
    logic [31:0] key;    // search word
    logic        match;  // expected flag
    logic [15:0] lines;  // expected encoded index
  } srow_t;

  logic             core_clk = 1'b0;  // 25 MHz
  logic             resetn = 1'b0, arrayClearn = 1'b1;
  logic             searchStrobe, writeStrobe, fetchStrobe, searchReady, writeDone;
  logic             fetchReady, fetchValid, irq, awready, wready, bvalid, arready, rvalid;
  logic [WIDTH-1:0] searchKey, fetchData;
  logic [IDX_W-1:0] fetchAddr;
  wrCmd_t           writeCmd;
  camResult_t       result, r0, r1;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic             rready = 1'b0;
  logic [7:0]       awaddr = '0, araddr = '0;
  logic [31:0]      wdata = '0, rdata, d;
  logic [3:0]       wstrb = '0;
  logic [1:0]       bresp, rresp, rs;
  logic             dn;
  int               n, cycles = 0, nFail = 0, samplesChecked = 0;
  // preload holds entry i = i, so keys map straight to indices
  srow_t            rows [5] = '{'{32'h0, 1'b1, 16'h0}, '{32'h1f, 1'b1, 16'h1f},
    '{32'he, 1'b1, 16'he}, '{32'h20, 1'b0, 16'h0}, '{32'hffff_ffff, 1'b0, 16'h0}};

  always #20 core_clk = ~core_clk;

  embedded_cam_block u_dut (.core_clk, .resetn, .arrayClearn, .searchStrobe, .searchKey,
    .searchReady, .writeStrobe, .writeCmd, .writeDone, .fetchStrobe, .fetchAddr, .fetchReady,
    .fetchValid, .fetchData, .result, .irq, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp);
  cam_user u_user (.core_clk, .searchReady, .writeDone, .fetchReady, .fetchValid,
    .fetchData, .result, .searchStrobe, .searchKey, .writeStrobe, .writeCmd, .fetchStrobe,
    .fetchAddr);

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nFail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // register write; address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge core_clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    fork
      begin
        do @(posedge core_clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge core_clk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    while (bvalid !== 1'b1) @(posedge core_clk);
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  // register read
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge core_clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge core_clk);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  // verdict, reached from the main flow or the hang guard
  task automatic finishTest();
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finishTest

  // hang guard, far above the 150 or so cycles the run needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      nFail++;
      finishTest();
    end
  end

  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (rows[i])
    begin
      u_user.search(rows[i].key, r0, r1);
      chk("match", 32'(r0.match), 32'(rows[i].match));
      chk("index", 32'(r0.lines), 32'(rows[i].lines));
    end
    $display("test table done");
    // masked entry needs the third cycle
    u_user.write('{5'd3, 32'h0000_ab00, 32'h0000_00ff}, 4, n, dn);
    chk("masked cycles", 32'(n), 32'd3);
    u_user.search(32'h0000_ab5c, r0, r1);
    chk("masked hit", 32'({r0.match, r0.lines}), 32'h0001_0003);
    u_user.search(32'h3, r0, r1);
    chk("old word gone", 32'(r0.match), 32'd0);
    // duplicate of entry 7 at 20, only looked at unencoded
    u_user.write('{5'd20, 32'h7, 32'h0}, 4, n, dn);
    chk("plain cycles", 32'(n), 32'd2);
    axw(OFS_CTRL, 32'h1, rs);
    u_user.search(32'h7, r0, r1);
    chk("low half", 32'({r0.phase, r0.match, r0.lines}), 32'h0001_0080);
    chk("high half", 32'({r1.phase, r1.match, r1.lines}), 32'h0003_0010);
    axr(OFS_HITS, d, rs);
    chk("hit vector", d, 32'h0010_0080);
    axr(OFS_RESULT, d, rs);
    chk("result reg", d, 32'h0000_0107);
    // every optional path register selected
    axw(OFS_CTRL, 32'h0000_01f8, rs);
    u_user.search(32'h5, r0, r1);
    chk("staged hit", 32'({r0.match, r0.lines}), 32'h0001_0005);
    $display("test write and modes done");
    // strobe dropped after one cycle stores nothing
    axw(OFS_CTRL, 32'h0, rs);
    u_user.write('{5'd9, 32'h1234, 32'h0}, 1, n, dn);
    chk("abort done", 32'(dn), 32'd0);
    u_user.search(32'h9, r0, r1);
    chk("abort kept", 32'({r0.match, r0.lines}), 32'h0001_0009);
    // lookup mode refuses writes, ram mode takes them
    axw(OFS_CTRL, 32'(MODE_ROM) << CTRL_MODE_LO, rs);
    chk("no search", 32'(searchReady), 32'd0);
    u_user.write('{5'd6, 32'h99, 32'h0}, 4, n, dn);
    chk("lookup write", 32'(dn), 32'd0);
    u_user.fetch(5'd6, d);
    chk("lookup word", d, 32'h6);
    axw(OFS_CTRL, 32'(MODE_RAM) << CTRL_MODE_LO, rs);
    u_user.write('{5'd6, 32'h99, 32'h0}, 4, n, dn);
    u_user.fetch(5'd6, d);
    chk("ram word", d, 32'h99);
    $display("test abort and fetch done");
    // events, mask, clear by writing one
    axr(OFS_STATUS, d, rs);
    chk("events", d, 32'h1f);
    chk("irq masked", 32'(irq), 32'd0);
    axw(OFS_MASK, 32'h10, rs);
    @(posedge core_clk);
    chk("irq raised", 32'(irq), 32'd1);
    axw(OFS_STATUS, 32'h10, rs);
    @(posedge core_clk);
    chk("irq cleared", 32'(irq), 32'd0);
    axr(OFS_STATUS, d, rs);
    chk("one cleared", d, 32'h0f);
    axr(8'h20, d, rs);
    chk("unmapped read", 32'(rs), 32'(RESP_SLVERR));
    axw(8'h24, 32'hffff_ffff, rs);
    chk("unmapped write", 32'(rs), 32'(RESP_SLVERR));
    $display("test registers done");
    // second reset restores registers and preload
    @(posedge core_clk);
    resetn      <= 1'b0;
    arrayClearn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn      <= 1'b1;
    arrayClearn <= 1'b1;
    chk("result", 32'(result), 32'd0);
    axr(OFS_CTRL, d, rs);
    chk("ctrl", d, CTRL_RESET);
    axr(OFS_MASK, d, rs);
    chk("mask", d, 32'(MASK_RESET));
    chk("irq", 32'(irq), 32'd0);
    u_user.search(32'h3, r0, r1);
    chk("preload", 32'({r0.match, r0.lines}), 32'h0001_0003);
    $display("test reset done");
    finishTest();
  end
endmodule : embedded_cam_block_tb
`default_nettype wire
